// *** tmesi_top.sv ***
// Event, shortcut and interrupt-enable logic of the two-wire master.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
module tmesi_top
  import tmesi_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire tmesi_pkg::tmesi_word_t hwdata,
  input wire logic hready,
  output tmesi_pkg::tmesi_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pause_task_in,
  input wire logic resume_task_in,
  input wire logic halt_task_in,
  input wire logic byte_boundary_event,
  input wire logic read_ack_done,
  input wire logic stopped_event,
  input wire logic rx_byte_ready_event,
  input wire logic tx_byte_sent_event,
  input wire logic fault_event,
  output logic pause_task_out,
  output logic halt_task_out,
  output logic bus_held,
  output logic pause_entered_event,
  output logic irq
);

  tmesi_reg_if #(.AW(AW)) bus ();

  tmesi_ahb_slave #(.AW(AW)) u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .bus(bus)
  );

  tmesi_word_t irq_en_q;
  tmesi_word_t status_q;
  tmesi_word_t ev_vec;
  logic [SH_W-1:0] event_task_shortcuts_q;
  tmesi_pause_t ps_q;
  logic short_pause;
  logic short_halt;
  logic pause_req;
  logic halt_req;
  logic pause_hit;
  logic wr_evt;
  logic wr_event_task_shortcuts;
  logic wr_set;
  logic wr_clr;
  logic rd_status;
  logic [11:0] reg_off;

  assign reg_off = bus.addr[11:0];
  assign wr_evt = bus.wr && (reg_off == OFF_PAUSE_EVT);
  assign wr_event_task_shortcuts = bus.wr && (reg_off == OFF_EVENT_TASK_SHORTCUTS);
  assign wr_set = bus.wr && (reg_off == OFF_IRQ_SET);
  assign wr_clr = bus.wr && (reg_off == OFF_IRQ_CLR);
  assign rd_status = bus.rd && (reg_off == OFF_IRQ_STATUS);

  assign short_pause = byte_boundary_event && event_task_shortcuts_q[SH_PAUSE_BIT];
  assign short_halt = byte_boundary_event && event_task_shortcuts_q[SH_HALT_BIT];
  assign pause_req = pause_task_in || short_pause;
  assign halt_req = halt_task_in || short_halt;
  // A halt or resume in the acknowledge cycle cancels the pause, so no event may fire.
  assign pause_hit = read_ack_done && (ps_q == PS_ARMED) && !halt_req && !resume_task_in;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      event_task_shortcuts_q <= RST_EVENT_TASK_SHORTCUTS[SH_W-1:0];
    end
    else if (wr_event_task_shortcuts)
    begin
      event_task_shortcuts_q <= bus.wdata[SH_W-1:0];
    end
  end

  // Pause only takes effect at the next read acknowledge; halt or resume abandons it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ps_q <= PS_RUN;
    end
    else
    begin
      case (ps_q)
        PS_RUN:
        begin
          if (pause_req && !halt_req && !resume_task_in)
          begin
            ps_q <= PS_ARMED;
          end
        end
        PS_ARMED:
        begin
          if (halt_req || resume_task_in)
          begin
            ps_q <= PS_RUN;
          end
          else if (read_ack_done)
          begin
            ps_q <= PS_HELD;
          end
        end
        PS_HELD:
        begin
          if (halt_req || resume_task_in)
          begin
            ps_q <= PS_RUN;
          end
        end
        default:
        begin
          ps_q <= PS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pause_task_out <= 1'b0;
      halt_task_out <= 1'b0;
      bus_held <= 1'b0;
    end
    else
    begin
      pause_task_out <= pause_req;
      halt_task_out <= halt_req;
      bus_held <= (ps_q == PS_HELD);
    end
  end

  // The hardware set wins over a software write of zero in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pause_entered_event <= 1'b0;
    end
    else if (pause_hit)
    begin
      pause_entered_event <= 1'b1;
    end
    else if (wr_evt)
    begin
      pause_entered_event <= bus.wdata[EVT_FLAG_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_en_q <= RST_IRQ_EN;
    end
    else if (wr_set)
    begin
      irq_en_q <= irq_en_q | (bus.wdata & EV_MASK);
    end
    else if (wr_clr)
    begin
      irq_en_q <= irq_en_q & ~(bus.wdata & EV_MASK);
    end
  end

  always_comb
  begin
    ev_vec = WORD_ZERO;
    ev_vec[EV_STOPPED_BIT] = stopped_event;
    ev_vec[EV_RX_READY_BIT] = rx_byte_ready_event;
    ev_vec[EV_TX_SENT_BIT] = tx_byte_sent_event;
    ev_vec[EV_FAULT_BIT] = fault_event;
    ev_vec[EV_BOUNDARY_BIT] = byte_boundary_event;
    ev_vec[EV_PAUSED_BIT] = pause_hit;
  end

  // A read clears the status, but an event in the same cycle survives it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= RST_STATUS;
    end
    else
    begin
      status_q <= (rd_status ? WORD_ZERO : status_q) | ev_vec;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_q & irq_en_q);
    end
  end

  always_comb
  begin
    case (reg_off)
      OFF_PAUSE_EVT: bus.rdata = {31'h0000_0000, pause_entered_event};
      OFF_EVENT_TASK_SHORTCUTS: bus.rdata = {30'h0000_0000, event_task_shortcuts_q};
      OFF_IRQ_SET: bus.rdata = irq_en_q;
      OFF_IRQ_CLR: bus.rdata = irq_en_q;
      OFF_IRQ_STATUS: bus.rdata = status_q;
      default: bus.rdata = WORD_ZERO;
    endcase
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_pause_fires;
    pause_hit |=> pause_entered_event && status_q[EV_PAUSED_BIT];
  endproperty
  a_pause_fires: assert property (p_pause_fires) else $error("Pause event missed.");

  property p_pause_needs_arm;
    $rose(pause_entered_event) && !$past(wr_evt) |-> $past(pause_hit);
  endproperty
  a_pause_needs_arm: assert property (p_pause_needs_arm) else $error("Pause event unarmed.");

  property p_held_stays;
    (ps_q == PS_HELD) && !resume_task_in && !halt_req |=> ##1 bus_held;
  endproperty
  a_held_stays: assert property (p_held_stays) else $error("Held state left early.");

  property p_held_enter;
    pause_hit |-> ##2 bus_held;
  endproperty
  a_held_enter: assert property (p_held_enter) else $error("Held state not entered.");

  property p_short_pause;
    byte_boundary_event && event_task_shortcuts_q[SH_PAUSE_BIT] |=> pause_task_out;
  endproperty
  a_short_pause: assert property (p_short_pause) else $error("Pause shortcut idle.");

  property p_short_halt;
    (halt_task_out != $past(halt_task_in)) |-> $past(short_halt);
  endproperty
  a_short_halt: assert property (p_short_halt) else $error("Halt shortcut wrong.");

  property p_en_stopped;
    wr_set && bus.wdata[EV_STOPPED_BIT] |=> irq_en_q[EV_STOPPED_BIT];
  endproperty
  a_en_stopped: assert property (p_en_stopped) else $error("Stopped enable lost.");

  property p_en_rx;
    wr_set && bus.wdata[EV_RX_READY_BIT] |=> irq_en_q[EV_RX_READY_BIT];
  endproperty
  a_en_rx: assert property (p_en_rx) else $error("Receive enable lost.");

  property p_en_tx;
    wr_set && bus.wdata[EV_TX_SENT_BIT] |=> irq_en_q[EV_TX_SENT_BIT];
  endproperty
  a_en_tx: assert property (p_en_tx) else $error("Sent enable lost.");

  property p_en_fault;
    wr_set && bus.wdata[EV_FAULT_BIT] |=> irq_en_q[EV_FAULT_BIT];
  endproperty
  a_en_fault: assert property (p_en_fault) else $error("Fault enable lost.");

  property p_en_bound;
    wr_set && bus.wdata[EV_BOUNDARY_BIT] |=> irq_en_q[EV_BOUNDARY_BIT];
  endproperty
  a_en_bound: assert property (p_en_bound) else $error("Boundary enable lost.");

  property p_en_paused;
    wr_set && bus.wdata[EV_PAUSED_BIT] |=> irq_en_q[EV_PAUSED_BIT];
  endproperty
  a_en_paused: assert property (p_en_paused) else $error("Paused enable lost.");

  property p_bound_sticky;
    byte_boundary_event |=> status_q[EV_BOUNDARY_BIT];
  endproperty
  a_bound_sticky: assert property (p_bound_sticky) else $error("Boundary flag lost.");

  property p_clear;
    wr_clr |=> (irq_en_q & $past(bus.wdata) & EV_MASK) == WORD_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("Enable not cleared.");

  property p_zero_keeps;
    wr_set |=> ((irq_en_q ^ $past(irq_en_q)) & ~$past(bus.wdata)) == WORD_ZERO;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("Zero bit changed enable.");

  property p_irq_level;
    (|(status_q & irq_en_q)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");

  c_held: cover property (pause_hit ##2 bus_held);
  c_halt_short: cover property (short_halt ##1 halt_task_out);
  c_irq: cover property ($rose(irq));

endmodule

// *** tmesi_pkg.sv ***
// Package with the register map, field layout and state types of the two-wire event block.
package tmesi_pkg;

  typedef logic [31:0] tmesi_word_t;

  // Register byte offsets.
  localparam logic [11:0] OFF_PAUSE_EVT = 12'h148;
  localparam logic [11:0] OFF_EVENT_TASK_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h310;

  // Reset values.
  localparam tmesi_word_t RST_EVENT_TASK_SHORTCUTS = 32'h0000_0000;
  localparam tmesi_word_t RST_IRQ_EN = 32'h0000_0000;
  localparam tmesi_word_t RST_STATUS = 32'h0000_0000;
  localparam tmesi_word_t WORD_ZERO = 32'h0000_0000;

  // Shortcut field positions.
  localparam int SH_PAUSE_BIT = 0;
  localparam int SH_HALT_BIT = 1;
  localparam int SH_W = 2;

  // Event field positions, shared by the enable, clear and status registers.
  localparam int EV_STOPPED_BIT = 1;
  localparam int EV_RX_READY_BIT = 2;
  localparam int EV_TX_SENT_BIT = 7;
  localparam int EV_FAULT_BIT = 9;
  localparam int EV_BOUNDARY_BIT = 14;
  localparam int EV_PAUSED_BIT = 18;
  localparam tmesi_word_t EV_MASK = 32'h0004_4286;

  // Event register flag position.
  localparam int EVT_FLAG_BIT = 0;

  // Bus constants.
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam int MIN_ADDR_W = 12;
  localparam int MAX_ADDR_W = 32;
  localparam int WORD_LSB_W = 2;

  typedef enum logic [1:0] {PS_RUN, PS_ARMED, PS_HELD} tmesi_pause_t;
  typedef enum logic {SL_IDLE, SL_ACCESS} tmesi_slave_t;

endpackage

// *** tmesi_reg_if.sv ***
// Interface between the bus slave and the register file.
`timescale 1ns/1ns
interface tmesi_reg_if #(parameter int AW = 12);
  logic wr;
  logic rd;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output wr, output rd, output addr, output wdata, input rdata);
  modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// *** tmesi_ahb_slave.sv ***
// AHB-Lite slave front end with one wait state per transfer.
`timescale 1ns/1ns
module tmesi_ahb_slave
  import tmesi_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire tmesi_pkg::tmesi_word_t hwdata,
  input wire logic hready,
  output tmesi_pkg::tmesi_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  tmesi_reg_if.slave bus
);

  tmesi_slave_t st_q;
  logic [AW-1:0] addr_q;
  logic write_q;

  generate
    if (AW < MIN_ADDR_W || AW > MAX_ADDR_W)
    begin : g_bad_aw
      $error("Address width cannot reach the register map.");
    end
  endgenerate

  // The wait state lets read data come from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= SL_IDLE;
      hreadyout <= 1'b1;
      addr_q <= '0;
      write_q <= 1'b0;
      hrdata <= WORD_ZERO;
    end
    else
    begin
      case (st_q)
        SL_IDLE:
        begin
          if (hsel && hready && htrans[HTRANS_ACTIVE_BIT])
          begin
            st_q <= SL_ACCESS;
            hreadyout <= 1'b0;
            addr_q <= {haddr[AW-1:WORD_LSB_W], {WORD_LSB_W{1'b0}}};
            write_q <= hwrite;
          end
        end
        SL_ACCESS:
        begin
          st_q <= SL_IDLE;
          hreadyout <= 1'b1;
          if (!write_q)
          begin
            hrdata <= bus.rdata;
          end
        end
        default:
        begin
          st_q <= SL_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  assign bus.wr = (st_q == SL_ACCESS) && write_q;
  assign bus.rd = (st_q == SL_ACCESS) && !write_q;
  assign bus.addr = addr_q;
  assign bus.wdata = hwdata;

endmodule

// *** tmesi_engine_model.sv ***
// Behavioural model of the two-wire engine strobes that face the event block.
`timescale 1ns/1ns
module tmesi_engine_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic byte_req,
  output logic byte_boundary_event,
  output logic rx_byte_ready_event,
  output logic read_ack_done
);
  logic [3:0] step_q;

  // A read byte runs boundary, data ready and then the acknowledge bit.
  // The gap before the acknowledge leaves room for a shortcut to arm the pause.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_q <= 4'h0;
    end
    else if (byte_req && step_q == 4'h0)
    begin
      step_q <= 4'h1;
    end
    else if (step_q != 4'h0)
    begin
      step_q <= step_q + 4'h1;
    end
  end

  assign byte_boundary_event = (step_q == 4'h1);
  assign rx_byte_ready_event = (step_q == 4'h8);
  assign read_ack_done = (step_q == 4'hA);
endmodule

// *** twi_master_event_shortcut_irq_tb_top.sv ***
// Self-checking testbench of the two-wire event, shortcut and interrupt block.
`timescale 1ns/1ns
module twi_master_event_shortcut_irq_tb_top;
  import tmesi_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  tmesi_word_t hwdata = 32'h0000_0000;
  tmesi_word_t hrdata, rd, en, r;
  logic hreadyout, hresp, bb_ev, rx_ev, ack_done;
  logic pause_out, halt_out, bus_held, paused_ev, irq;
  logic [6:0] strb = 7'h00;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_pause = 0;
  int n_halt = 0;
  int seed = 58;
  int k;
  int ev_bit[6] = '{1, 7, 9, 2, 14, 18};

  always #5 hclk = ~hclk;

  tmesi_top #(.AW(12)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pause_task_in(strb[3]),
    .resume_task_in(strb[4]), .halt_task_in(strb[5]), .byte_boundary_event(bb_ev),
    .read_ack_done(ack_done), .stopped_event(strb[0]), .rx_byte_ready_event(rx_ev),
    .tx_byte_sent_event(strb[1]), .fault_event(strb[2]), .pause_task_out(pause_out),
    .halt_task_out(halt_out), .bus_held(bus_held), .pause_entered_event(paused_ev), .irq(irq));

  tmesi_engine_model eng_u (.hclk(hclk), .hresetn(hresetn), .byte_req(strb[6]),
    .byte_boundary_event(bb_ev), .rx_byte_ready_event(rx_ev), .read_ack_done(ack_done));

  // Task pulses are counted here so that a single-cycle output is never missed.
  always @(posedge hclk)
  begin
    cycles++;
    n_pause += (pause_out === 1'b1);
    n_halt += (halt_out === 1'b1);
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  function automatic tmesi_word_t next_en(tmesi_word_t old, tmesi_word_t v, logic set);
    return set ? (old | (v & EV_MASK)) : (old & ~(v & EV_MASK));
  endfunction

  task automatic check(input tmesi_word_t seen, input tmesi_word_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [11:0] a, input tmesi_word_t wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(tmesi_word_t'(hresp), WORD_ZERO);
  endtask

  task automatic wr(input logic [11:0] a, input tmesi_word_t d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input tmesi_word_t exp);
    ahb(1'b0, a, WORD_ZERO);
    check(rd, exp);
  endtask

  task automatic fire(input int i);
    strb[i] <= 1'b1;
    @(posedge hclk);
    strb <= 7'h00;
    @(posedge hclk);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(OFF_EVENT_TASK_SHORTCUTS, RST_EVENT_TASK_SHORTCUTS);
    rdchk(OFF_IRQ_SET, RST_IRQ_EN);
    rdchk(OFF_IRQ_CLR, RST_IRQ_EN);
    rdchk(12'h0FC, WORD_ZERO);
    en = RST_IRQ_EN;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_IRQ_SET, 32'h1 << ev_bit[i]);
      en = next_en(en, 32'h1 << ev_bit[i], 1'b1);
      rdchk(OFF_IRQ_SET, en);
    end
    wr(OFF_IRQ_SET, WORD_ZERO);
    rdchk(OFF_IRQ_SET, en);
    // Random set and clear patterns, including bits outside the event fields.
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      wr(i % 2 ? OFF_IRQ_SET : OFF_IRQ_CLR, r);
      en = next_en(en, r, i % 2);
      rdchk(OFF_IRQ_SET, en);
      rdchk(OFF_IRQ_CLR, en);
    end
    wr(OFF_IRQ_CLR, 32'hFFFF_FFFF);
    rdchk(OFF_IRQ_STATUS, WORD_ZERO);
    // Each direct event interrupts only while its enable is set.
    for (int i = 0; i < 3; i++)
    begin
      fire(i);
      @(posedge hclk);
      check(tmesi_word_t'(irq), WORD_ZERO);
      rdchk(OFF_IRQ_STATUS, 32'h1 << ev_bit[i]);
      wr(OFF_IRQ_SET, 32'h1 << ev_bit[i]);
      fire(i);
      @(posedge hclk);
      check(tmesi_word_t'(irq), 32'h1);
      rdchk(OFF_IRQ_STATUS, 32'h1 << ev_bit[i]);
      @(posedge hclk);
      check(tmesi_word_t'(irq), WORD_ZERO);
      wr(OFF_IRQ_CLR, 32'h1 << ev_bit[i]);
    end
    // A read acknowledge without a pending pause must not pause.
    fire(6);
    repeat (16) @(posedge hclk);
    check(tmesi_word_t'(paused_ev), WORD_ZERO);
    check(tmesi_word_t'(n_pause), WORD_ZERO);
    rdchk(OFF_IRQ_STATUS, 32'h0000_4004);
    // Boundary with the pause link set arms the pause before the acknowledge.
    wr(OFF_EVENT_TASK_SHORTCUTS, 32'h1);
    rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h1);
    wr(OFF_IRQ_SET, 32'h1 << EV_PAUSED_BIT);
    fire(6);
    k = 0;
    while (paused_ev !== 1'b1 && k < 40)
    begin
      @(posedge hclk);
      k++;
    end
    check(tmesi_word_t'(paused_ev), 32'h1);
    check(tmesi_word_t'(n_pause), 32'h1);
    repeat (2) @(posedge hclk);
    check(tmesi_word_t'(bus_held), 32'h1);
    check(tmesi_word_t'(irq), 32'h1);
    rdchk(OFF_PAUSE_EVT, 32'h1);
    rdchk(OFF_IRQ_STATUS, 32'h0004_4004);
    fire(4);
    repeat (2) @(posedge hclk);
    check(tmesi_word_t'(bus_held), WORD_ZERO);
    wr(OFF_PAUSE_EVT, WORD_ZERO);
    rdchk(OFF_PAUSE_EVT, WORD_ZERO);
    // Halt link, and direct task pulses passing through.
    wr(OFF_EVENT_TASK_SHORTCUTS, 32'h2);
    fire(6);
    repeat (16) @(posedge hclk);
    check(tmesi_word_t'(n_halt), 32'h1);
    check(tmesi_word_t'(n_pause), 32'h1);
    fire(3);
    fire(5);
    @(posedge hclk);
    check(tmesi_word_t'(n_pause), 32'h2);
    check(tmesi_word_t'(n_halt), 32'h2);
    wr(OFF_EVENT_TASK_SHORTCUTS, 32'hFFFF_FFFF);
    rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h3);
    stop_test();
  end
endmodule
